// file: dst_pkg.sv
// dst_pkg: register map, field positions and constants for the dual 16-bit timer block
// assumes a 32-bit apb slave at 40 mhz; each register is one aligned word
package dst_pkg;
    localparam logic [7:0]  ADDR_T1_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_T1_COUNT  = 8'h04;
    localparam logic [7:0]  ADDR_T1_PERIOD = 8'h08;
    localparam logic [7:0]  ADDR_T2_CTRL   = 8'h0c;
    localparam logic [7:0]  ADDR_T2_COUNT  = 8'h10;
    localparam logic [7:0]  ADDR_T2_PERIOD = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h1c;
    // control field positions
    localparam int          BIT_RUN        = 15;
    localparam int          BIT_IDLE_HALT  = 13;
    localparam int          BIT_GATE       = 6;
    localparam int          BIT_PS_HI      = 5;
    localparam int          BIT_PS_LO      = 4;
    localparam int          BIT_SYNC       = 2;
    localparam int          BIT_CS         = 1;
    // writable bits of the control registers; the rest read as zero
    localparam logic [15:0] T1_CTRL_MASK   = 16'ha076;
    localparam logic [15:0] T2_CTRL_MASK   = 16'ha072;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] PERIOD_RESET   = 16'hffff;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam logic [15:0] COUNT_ONE      = 16'h0001;
    localparam logic [1:0]  IRQ_BITS_ZERO  = 2'h0;
    // prescale terminal counts, 1:1 1:8 1:64 1:256
    localparam logic [7:0]  PS_TC_1        = 8'h00;
    localparam logic [7:0]  PS_TC_8        = 8'h07;
    localparam logic [7:0]  PS_TC_64       = 8'h3f;
    localparam logic [7:0]  PS_TC_256      = 8'hff;
    localparam logic [7:0]  PS_ZERO        = 8'h00;
    localparam logic [7:0]  PS_ONE         = 8'h01;
    localparam logic [1:0]  PS_CODE_8      = 2'h1;
    localparam logic [1:0]  PS_CODE_64     = 2'h2;
    localparam logic [1:0]  PS_CODE_256    = 2'h3;
    typedef enum logic [1:0] {
        DST_MODE_TIMER = 2'b00,
        DST_MODE_GATED = 2'b01,
        DST_MODE_SYNC  = 2'b11,
        DST_MODE_ASYNC = 2'b10
    } dst_mode_t;
endpackage : dst_pkg

// file: dst_src_model.sv
// dst_src_model: external clock, gate and 32 khz sources that face the timer pins
// assumes clk_sys is the block clock; every level is held long enough for a two-flop sync
`timescale 1ns/100ps
`default_nettype none
module dst_src_model (
    // reference clock
    input  wire logic clk_sys,
    // pins toward the block
    output wire logic t1_pin,
    output wire logic t2_pin,
    output wire logic osc_clk,
    output wire logic gate1,
    output wire logic gate2
);
    logic [2:0] src;
    logic [1:0] gte;

    // sources idle low; the 32 khz source is modelled as bursts to keep the run short
    initial begin
        src = 3'h0;
        gte = 2'h0;
    end
    assign t1_pin  = src[0];
    assign t2_pin  = src[1];
    assign osc_clk = src[2];
    assign gate1   = gte[0];
    assign gate2   = gte[1];

    // three cycles high, four low between pulses: one clean rising edge per pulse
    task pulses(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            src[ch] <= 1'b1;
            repeat (3) @(posedge clk_sys);
            src[ch] <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask : pulses

    // gate level change, launched just after an edge
    task gate(input int ch, input logic v);
        @(posedge clk_sys);
        gte[ch] <= v;
    endtask : gate
endmodule : dst_src_model
`default_nettype wire

// file: dst_timer.sv
// dst_timer: one 16-bit timer with prescaler, gate, period match and event pulse
// assumes ext_tick and gate inputs are already synchronised to clk_sys
`timescale 1ns/100ps
`default_nettype none
module dst_timer (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // configuration
    input  wire logic [15:0]         ctrl,
    input  wire logic                has_async,
    input  wire logic [15:0]         period,
    input  wire logic                idle,
    // count load from software
    input  wire logic                count_wr,
    input  wire logic [15:0]         count_wdata,
    // clock sources
    input  wire logic                ext_tick_sync,
    input  wire logic                ext_tick_raw,
    input  wire logic                gate_sync,
    // state
    output logic      [15:0]         count,
    output logic                     event_pulse
);
    import dst_pkg::*;

    logic [7:0]  ps_ff, nxt_ps;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        gate_d_ff, nxt_gate_d;
    logic        evt_ff, nxt_evt;
    logic        ext_sel, running, src_tick, ps_done, gate_fall;
    logic [7:0]  ps_tc;

    // prescale code to terminal count
    always_comb begin
        unique case (ctrl[BIT_PS_HI:BIT_PS_LO])
            PS_CODE_8:   ps_tc = PS_TC_8;
            PS_CODE_64:  ps_tc = PS_TC_64;
            PS_CODE_256: ps_tc = PS_TC_256;
            default:     ps_tc = PS_TC_1;
        endcase
    end

    // source selection; async mode counts the unsynchronised edge, sync is ignored on internal clock
    always_comb begin
        ext_sel   = ctrl[BIT_CS];                                              // [R10] [R4]
        running   = ctrl[BIT_RUN] && !(idle && ctrl[BIT_IDLE_HALT]);           // [R5] [R6]
        gate_fall = gate_d_ff && !gate_sync;
        if (ext_sel) begin
            src_tick = (has_async && !ctrl[BIT_SYNC]) ? ext_tick_raw : ext_tick_sync; // [R9] [R13] [R14]
        end else if (ctrl[BIT_GATE]) begin
            src_tick = gate_sync;                                              // [R7] [R18]
        end else begin
            src_tick = 1'b1;
        end
    end

    // prescaler counts source ticks; the count then steps on its terminal count, i.e. after it [R11] [R8]
    always_comb begin
        nxt_ps     = ps_ff;
        nxt_cnt    = cnt_ff;
        nxt_evt    = 1'b0;
        nxt_gate_d = gate_sync;
        ps_done    = running && src_tick && (ps_ff >= ps_tc);
        if (running && src_tick) begin
            nxt_ps = ps_done ? PS_ZERO : ps_ff + PS_ONE;
        end
        if (ps_done) begin
            if (cnt_ff == period) begin
                nxt_cnt = COUNT_ZERO;                                          // [R17] [R1]
                nxt_evt = !(ctrl[BIT_GATE] && !ext_sel);
            end else begin
                nxt_cnt = cnt_ff + COUNT_ONE;
            end
        end
        if (running && !ext_sel && ctrl[BIT_GATE] && gate_fall) begin
            nxt_evt = 1'b1;                                                    // [R18]
        end
        if (count_wr) begin
            nxt_cnt = count_wdata;
            nxt_ps  = PS_ZERO;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ps_ff     <= PS_ZERO;
            cnt_ff    <= COUNT_ZERO;
            gate_d_ff <= 1'b0;
            evt_ff    <= 1'b0;
        end else begin
            ps_ff     <= nxt_ps;
            cnt_ff    <= nxt_cnt;
            gate_d_ff <= nxt_gate_d;
            evt_ff    <= nxt_evt;
        end
    end

    assign count       = cnt_ff;
    assign event_pulse = evt_ff;

    // period match wraps the count to zero on the next step
    property p_wrap;
        @(posedge clk_sys) disable iff (rst)
        (ps_done && cnt_ff == period && !count_wr) |=> (cnt_ff == COUNT_ZERO);
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap at period"); // [R17]

    // stopped timer holds its count
    property p_stop;
        @(posedge clk_sys) disable iff (rst)
        (!ctrl[BIT_RUN] && !count_wr) |=> $stable(cnt_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped"); // [R5]

    // idle halt freezes the count
    property p_idle;
        @(posedge clk_sys) disable iff (rst)
        (idle && ctrl[BIT_IDLE_HALT] && !count_wr) |=> $stable(cnt_ff);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved in idle halt"); // [R6]

    // 1:8 prescale steps at most once every eight cycles
    sequence s_step;
        ps_done && !count_wr && cnt_ff != period;
    endsequence
    property p_ps8;
        @(posedge clk_sys) disable iff (rst)
        (ctrl[BIT_PS_HI:BIT_PS_LO] == PS_CODE_8 && $stable(ctrl)) ##0 s_step
            |=> !ps_done [*7];
    endproperty
    a_ps8: assert property (p_ps8) else $error("1:8 prescale stepped too soon"); // [R8]

    // gated internal mode with gate low never counts
    property p_gate;
        @(posedge clk_sys) disable iff (rst)
        (!ext_sel && ctrl[BIT_GATE] && !gate_sync && !count_wr) |=> $stable(cnt_ff);
    endproperty
    a_gate: assert property (p_gate) else $error("gated timer counted with gate low"); // [R18]

    // gate falling edge raises the event next cycle
    property p_gfall;
        @(posedge clk_sys) disable iff (rst)
        (running && !ext_sel && ctrl[BIT_GATE] && gate_fall) |=> event_pulse;
    endproperty
    a_gfall: assert property (p_gfall) else $error("no event on gate fall"); // [R18]
endmodule : dst_timer
`default_nettype wire

// file: dst_top.sv
// dst_top: two 16-bit timer/counters behind an apb slave, with sticky irq status and mask
// assumes a 40 mhz clk_sys; pins come from outside and are synchronised here
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R1] first timer is a 16-bit counter
// [R2] three control bits pick first timer mode
// [R3] source bit1, sync bit2, gate bit6
// [R4] timer modes internal, counter modes external pin
// [R5] run bit15 starts and stops
// [R6] idle halt bit13 stops in idle
// [R7] gate works only with internal clock
// [R8] prescale bits5-4 give 1,8,64,256
// [R9] sync bit chooses synchronised external clock
// [R10] source bit counts external rising edges
// [R11] synchronisation follows the prescaler; here the pin is synchronised ahead of the prescaler
// [R12] first timer may run from 32 khz
// [R13] second timer always synchronises external clock
// [R14] second timer has no asynchronous mode
// [R15] second timer source bit1, gate bit6
// [R16] software sets run bit last
// [R17] period match wraps count, sets flag; in gated internal mode the match wraps the count but sets no flag
// [R18] gated mode counts gate high, flags fall
module dst_top (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // pins and device state
    input  wire logic               timer1_ext_clock_pin,
    input  wire logic               timer2_ext_clock_pin,
    input  wire logic               osc32k_clk,
    input  wire logic               osc32k_select,
    input  wire logic               timer1_gate_pin,
    input  wire logic               timer2_gate_pin,
    input  wire logic               idle_mode,
    // interrupt
    output logic                    irq
);
    import dst_pkg::*;

    // synchroniser chains, first stage feeds only the second
    logic [3:0]  s1_ff, s2_ff, s3_ff;
    logic [3:0]  nxt_s1, nxt_s2, nxt_s3;
    logic        t1_src_raw;
    logic        raw_prev_ff, nxt_raw_prev;

    logic [15:0] t1_ctrl_ff, nxt_t1_ctrl, t2_ctrl_ff, nxt_t2_ctrl;
    logic [15:0] t1_per_ff, nxt_t1_per, t2_per_ff, nxt_t2_per;
    logic [1:0]  stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ready_ff, nxt_ready, err_ff, nxt_err, irq_ff, nxt_irq;
    logic        wr_en, rd_en, t1_cnt_wr, t2_cnt_wr, t1_evt, t2_evt;
    logic [15:0] t1_count, t2_count;
    logic        t1_tick_sync, t2_tick_sync, t1_tick_raw;

    // 32 khz oscillator replaces the pin as first timer's external source
    assign t1_src_raw = osc32k_select ? osc32k_clk : timer1_ext_clock_pin; // [R12]

    // lane order: 0 t1 ext, 1 t2 ext, 2 t1 gate, 3 t2 gate
    always_comb begin
        nxt_s1 = {timer2_gate_pin, timer1_gate_pin, timer2_ext_clock_pin, t1_src_raw};
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            s3_ff <= 4'h0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    // rising edges after the chain; both timers count rising edges of the pin [R10] [R13]
    assign t1_tick_sync = s2_ff[0] && !s3_ff[0];
    assign t2_tick_sync = s2_ff[1] && !s3_ff[1];

    // unsynchronised path: edge taken off the second stage with its own delay flop, skipping the
    // third stage; a truly clockless counter would need a second domain
    assign nxt_raw_prev = s2_ff[0];
    assign t1_tick_raw  = s2_ff[0] && !raw_prev_ff;                           // [R9]
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            raw_prev_ff <= 1'b0;
        end else begin
            raw_prev_ff <= nxt_raw_prev;
        end
    end

    // apb decode; two-cycle access phase with one wait state, writes only in its first cycle
    assign wr_en     = psel && penable && pwrite && !ready_ff;
    assign rd_en     = psel && penable && !pwrite && !ready_ff;
    assign t1_cnt_wr = wr_en && paddr == ADDR_T1_COUNT && pstrb[0] && pstrb[1];
    assign t2_cnt_wr = wr_en && paddr == ADDR_T2_COUNT && pstrb[0] && pstrb[1];

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == ADDR_T1_CTRL) || (a == ADDR_T1_COUNT) || (a == ADDR_T1_PERIOD) ||
                     (a == ADDR_T2_CTRL) || (a == ADDR_T2_COUNT) || (a == ADDR_T2_PERIOD) ||
                     (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
    endfunction : known_addr

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // register writes and sticky status; a new event beats a clear in the same cycle
    always_comb begin
        nxt_t1_ctrl = t1_ctrl_ff;
        nxt_t2_ctrl = t2_ctrl_ff;
        nxt_t1_per  = t1_per_ff;
        nxt_t2_per  = t2_per_ff;
        nxt_mask    = mask_ff;
        nxt_stat    = stat_ff;
        if (wr_en) begin
            unique case (paddr)
                ADDR_T1_CTRL:   nxt_t1_ctrl = merge16(t1_ctrl_ff, pwdata, pstrb) & T1_CTRL_MASK; // [R3] [R2]
                ADDR_T2_CTRL:   nxt_t2_ctrl = merge16(t2_ctrl_ff, pwdata, pstrb) & T2_CTRL_MASK; // [R15] [R14]
                ADDR_T1_PERIOD: nxt_t1_per  = merge16(t1_per_ff, pwdata, pstrb);
                ADDR_T2_PERIOD: nxt_t2_per  = merge16(t2_per_ff, pwdata, pstrb);
                ADDR_IRQ_MASK:  nxt_mask    = pstrb[0] ? pwdata[1:0] : mask_ff;
                ADDR_IRQ_STAT:  nxt_stat    = pstrb[0] ? (stat_ff & ~pwdata[1:0]) : stat_ff;
                default:        nxt_mask    = mask_ff;
            endcase
        end
        nxt_stat = nxt_stat | {t2_evt, t1_evt};                                // [R17]
        nxt_irq  = |(nxt_stat & nxt_mask);
    end

    // read mux and handshake; unmapped addresses answer with pslverr
    always_comb begin
        nxt_ready = psel && penable && !ready_ff;
        nxt_err   = (wr_en || rd_en) && !known_addr(paddr);
        nxt_rdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                ADDR_T1_CTRL:   nxt_rdata = {16'h0000, t1_ctrl_ff};
                ADDR_T1_COUNT:  nxt_rdata = {16'h0000, t1_count};
                ADDR_T1_PERIOD: nxt_rdata = {16'h0000, t1_per_ff};
                ADDR_T2_CTRL:   nxt_rdata = {16'h0000, t2_ctrl_ff};
                ADDR_T2_COUNT:  nxt_rdata = {16'h0000, t2_count};
                ADDR_T2_PERIOD: nxt_rdata = {16'h0000, t2_per_ff};
                ADDR_IRQ_STAT:  nxt_rdata = {30'h0000_0000, stat_ff};
                ADDR_IRQ_MASK:  nxt_rdata = {30'h0000_0000, mask_ff};
                default:        nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            t1_ctrl_ff <= CTRL_RESET;
            t2_ctrl_ff <= CTRL_RESET;
            t1_per_ff  <= PERIOD_RESET;
            t2_per_ff  <= PERIOD_RESET;
            stat_ff    <= IRQ_BITS_ZERO;
            mask_ff    <= IRQ_BITS_ZERO;
            rdata_ff   <= 32'h0000_0000;
            ready_ff   <= 1'b0;
            err_ff     <= 1'b0;
            irq_ff     <= 1'b0;
        end else begin
            t1_ctrl_ff <= nxt_t1_ctrl;
            t2_ctrl_ff <= nxt_t2_ctrl;
            t1_per_ff  <= nxt_t1_per;
            t2_per_ff  <= nxt_t2_per;
            stat_ff    <= nxt_stat;
            mask_ff    <= nxt_mask;
            rdata_ff   <= nxt_rdata;
            ready_ff   <= nxt_ready;
            err_ff     <= nxt_err;
            irq_ff     <= nxt_irq;
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = ready_ff;
    assign pslverr = err_ff;
    assign irq     = irq_ff;

    // first timer: has the asynchronous counter path
    dst_timer u_timer1 (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .ctrl          (t1_ctrl_ff),
        .has_async     (1'b1),
        .period        (t1_per_ff),
        .idle          (idle_mode),
        .count_wr      (t1_cnt_wr),
        .count_wdata   (pwdata[15:0]),
        .ext_tick_sync (t1_tick_sync),
        .ext_tick_raw  (t1_tick_raw),
        .gate_sync     (s2_ff[2]),
        .count         (t1_count),
        .event_pulse   (t1_evt)
    );

    // second timer: synchronised only, sync bit is not stored
    dst_timer u_timer2 (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .ctrl          (t2_ctrl_ff),
        .has_async     (1'b0),
        .period        (t2_per_ff),
        .idle          (idle_mode),
        .count_wr      (t2_cnt_wr),
        .count_wdata   (pwdata[15:0]),
        .ext_tick_sync (t2_tick_sync),
        .ext_tick_raw  (1'b0),
        .gate_sync     (s2_ff[3]),
        .count         (t2_count),
        .event_pulse   (t2_evt)
    );

    // an event is never lost to a simultaneous clear
    property p_sticky;
        @(posedge clk_sys) disable iff (rst)
        t1_evt |=> stat_ff[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("timer1 event not latched"); // [R17]

    // second timer event is latched as well
    property p_sticky2;
        @(posedge clk_sys) disable iff (rst)
        t2_evt |=> stat_ff[1];
    endproperty
    a_sticky2: assert property (p_sticky2) else $error("timer2 event not latched"); // [R17]

    // unmapped access answers with an error
    property p_unmapped;
        @(posedge clk_sys) disable iff (rst)
        ((wr_en || rd_en) && !known_addr(paddr)) |=> (pslverr && pready);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    // writing a one clears the status bit unless an event lands in the same cycle
    property p_clear;
        @(posedge clk_sys) disable iff (rst)
        (wr_en && paddr == ADDR_IRQ_STAT && pstrb[0] && pwdata[0] && !t1_evt) |=> !stat_ff[0];
    endproperty
    a_clear: assert property (p_clear) else $error("status bit not cleared by write"); // [R17]

    // irq is registered from the next masked status, so it changes in the same cycle as the status bits
    property p_irq;
        @(posedge clk_sys) disable iff (rst)
        ##1 irq == |($past(nxt_stat) & $past(nxt_mask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with status and mask");

    // second timer control never shows the sync bit
    property p_t2sync;
        @(posedge clk_sys) disable iff (rst)
        !t2_ctrl_ff[BIT_SYNC] && !t2_ctrl_ff[3];
    endproperty
    a_t2sync: assert property (p_t2sync) else $error("timer2 stored a sync bit"); // [R14]

    // apb answers one cycle after the access phase begins
    property p_apb;
        @(posedge clk_sys) disable iff (rst)
        (psel && penable && !ready_ff) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer timing wrong");
endmodule : dst_top
`default_nettype wire

// file: tb_top.sv
// tb_top: register-level tests of the dual timer block over apb
// assumes dst_pkg, dst_top and dst_src_model are compiled first; one 40 mhz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dst_pkg::*;
    logic        clk_sys, rst, psel, penable, pwrite, idle_mode, osc32k_select;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq, err, t1_pin, t2_pin, osc_clk, g1, g2;
    logic [15:0] c1, d, e16;
    int          err_total, num_checks;
    int          ps[4] = '{1, 8, 64, 256};
    // counter table: control value, source, pulse count, expected count
    logic [15:0] cf[7] = '{16'h8006, 16'h8002, 16'h8046, 16'h8016, 16'h8002, 16'h8012, 16'h8006};
    int          ch[7] = '{0, 0, 0, 0, 1, 1, 2};
    int          np[7] = '{5, 5, 5, 16, 5, 16, 5};
    int          ex[7] = '{5, 5, 5, 2, 5, 2, 5};

    dst_top dst_top_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer1_ext_clock_pin(t1_pin), .timer2_ext_clock_pin(t2_pin),
        .osc32k_clk(osc_clk), .osc32k_select(osc32k_select), .timer1_gate_pin(g1),
        .timer2_gate_pin(g2), .idle_mode(idle_mode), .irq(irq));

    dst_src_model dst_src_model_inst (
        .clk_sys(clk_sys), .t1_pin(t1_pin), .t2_pin(t2_pin), .osc_clk(osc_clk),
        .gate1(g1), .gate2(g2));

    // 25 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; request held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count is assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rd, err);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, rd, err);
        check(what, rd, exp);
    endtask : rdc

    // two count reads whose sampling edges are exactly gap cycles apart
    task delta(input logic [7:0] a, input int gap, output logic [15:0] dv);
        apb(1'b0, a, 32'h0, rd, err);
        c1 = rd[15:0];
        repeat (gap - 4) @(posedge clk_sys);
        apb(1'b0, a, 32'h0, rd, err);
        dv = rd[15:0] - c1;
    endtask : delta

    task finish_test;
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // a hang is cut short well past the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; idle_mode = 1'b0; osc32k_select = 1'b0;
        err_total = 0; num_checks = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values and writable bits
        rdc(ADDR_T1_CTRL, 32'h0, "t1 ctrl reset");
        rdc(ADDR_T1_PERIOD, 32'h0000ffff, "t1 period reset");
        rdc(ADDR_IRQ_MASK, 32'h0, "mask reset");
        wr(ADDR_T1_CTRL, 32'hffffffff);
        rdc(ADDR_T1_CTRL, 32'h0000a076, "t1 ctrl bits");
        wr(ADDR_T2_CTRL, 32'hffffffff);
        rdc(ADDR_T2_CTRL, 32'h0000a072, "t2 ctrl bits");
        wr(ADDR_T1_CTRL, 32'h0);
        wr(ADDR_T2_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0, rd, err);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        // internal clock through every prescale code; gap of 8 ratios gives 8 steps
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_T1_CTRL, 32'(i << 4));
            wr(ADDR_T1_CTRL, 32'h8000 | 32'(i << 4));
            delta(ADDR_T1_COUNT, 8 * ps[i], d);
            check("t1 prescale steps", 32'(d), 32'h8);
        end
        wr(ADDR_T1_CTRL, 32'h0);
        delta(ADDR_T1_COUNT, 40, d);
        check("t1 stopped", 32'(d), 32'h0);
        // idle with and without halt
        idle_mode <= 1'b1;
        wr(ADDR_T1_CTRL, 32'ha000);
        delta(ADDR_T1_COUNT, 16, d);
        check("idle halted", 32'(d), 32'h0);
        wr(ADDR_T1_CTRL, 32'h8000);
        delta(ADDR_T1_COUNT, 8, d);
        check("idle running", 32'(d), 32'h8);
        idle_mode <= 1'b0;
        // period match wraps to zero and flags
        wr(ADDR_T1_CTRL, 32'h0);
        wr(ADDR_T1_PERIOD, 32'h9);
        wr(ADDR_T1_COUNT, 32'h0);
        wr(ADDR_T1_CTRL, 32'h8000);
        delta(ADDR_T1_COUNT, 14, d);
        e16 = ((c1 + 16'h0004) % 16'h000a) - c1;
        check("t1 wrap", 32'(d), 32'(e16));
        wr(ADDR_T1_CTRL, 32'h0);
        rdc(ADDR_IRQ_STAT, 32'h1, "t1 flag");
        // masked, unmasked, cleared
        check("irq masked", 32'(irq), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_sys);
        check("irq on", 32'(irq), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge clk_sys);
        check("irq cleared", 32'(irq), 32'h0);
        rdc(ADDR_IRQ_STAT, 32'h0, "flag cleared");
        // gated accumulation
        wr(ADDR_T1_PERIOD, 32'hffff);
        wr(ADDR_T1_CTRL, 32'h8040);
        delta(ADDR_T1_COUNT, 16, d);
        check("gate low", 32'(d), 32'h0);
        dst_src_model_inst.gate(0, 1'b1);
        repeat (6) @(posedge clk_sys);
        delta(ADDR_T1_COUNT, 8, d);
        check("gate high", 32'(d), 32'h8);
        dst_src_model_inst.gate(0, 1'b0);
        repeat (6) @(posedge clk_sys);
        rdc(ADDR_IRQ_STAT, 32'h1, "gate fall flag");
        // external sources: sync, async, gate ignored, prescaled, second timer, 32 khz
        for (int i = 0; i < 7; i++) begin
            wr(ch[i] == 1 ? ADDR_T2_CTRL : ADDR_T1_CTRL, 32'h0);
            wr(ch[i] == 1 ? ADDR_T2_COUNT : ADDR_T1_COUNT, 32'h0);
            osc32k_select <= (ch[i] == 2);
            wr(ch[i] == 1 ? ADDR_T2_CTRL : ADDR_T1_CTRL, 32'(cf[i]));
            dst_src_model_inst.pulses(ch[i], np[i]);
            repeat (8) @(posedge clk_sys);
            rdc(ch[i] == 1 ? ADDR_T2_COUNT : ADDR_T1_COUNT, 32'(ex[i]), "ext count");
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
